// ---- hdl/supply_monitor_trim_regs.sv ----
// Registers 09h..0Bh: supply and battery trip selects, reseal, trim copies.
// Assumes comparator outputs arrive from the analog domain unsynchronised.
`default_nettype none
module supply_monitor_trim_regs #(
  parameter logic [7:0] trim_preset = supply_trim_pkg::trim_preset_default
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire supply_trim_pkg::reg_access_type bus,
  input wire logic status_read_stop,
  input wire logic auto_clear_enable,
  input wire logic status_flag_clear,
  input wire logic main_powerup,
  input wire logic [12:0] main_supply_mv,
  input wire logic [12:0] battery_mv,
  output logic [7:0] rdata,
  output logic clear_stamps_pulse,
  output logic battery_connected,
  output logic [12:0] main_trip_mv,
  output logic [12:0] first_trip_mv,
  output logic [12:0] second_trip_mv,
  output var supply_trim_pkg::low_flags_type flags,
  output var supply_trim_pkg::digital_trim_type initial_digital_trim,
  output logic [5:0] initial_analog_trim,
  output logic [1:0] pulse_adjust
);
  function automatic logic [12:0] main_level(input logic [2:0] s);
    case (s)
      3'h0: main_level = 13'd2295;
      3'h1: main_level = 13'd2550;
      3'h2: main_level = 13'd2805;
      3'h3: main_level = 13'd3060;
      3'h4: main_level = 13'd4250;
      3'h5: main_level = 13'd4675;
      default: main_level = supply_trim_pkg::level_reserved;
    endcase
  endfunction

  function automatic logic [12:0] first_level(input logic [2:0] s);
    case (s)
      3'h0: first_level = 13'd2125;
      3'h1: first_level = 13'd2295;
      3'h2: first_level = 13'd2550;
      3'h3: first_level = 13'd2805;
      3'h4: first_level = 13'd3060;
      3'h5: first_level = 13'd4250;
      3'h6: first_level = 13'd4675;
      default: first_level = supply_trim_pkg::level_reserved;
    endcase
  endfunction

  function automatic logic [12:0] second_level(input logic [2:0] s);
    case (s)
      3'h0: second_level = 13'd1875;
      3'h1: second_level = 13'd2025;
      3'h2: second_level = 13'd2250;
      3'h3: second_level = 13'd2475;
      3'h4: second_level = 13'd2700;
      3'h5: second_level = 13'd3750;
      3'h6: second_level = 13'd4125;
      default: second_level = supply_trim_pkg::level_reserved;
    endcase
  endfunction

  logic [2:0] supply_sel_reg, supply_sel_next;
  logic [2:0] first_sel_reg, first_sel_next;
  logic [2:0] second_sel_reg, second_sel_next;
  logic disconnect_reg, disconnect_next;
  logic clear_reg, clear_next;
  logic [7:0] trim_reg, trim_next;
  logic trim_loaded_reg, trim_loaded_next;
  supply_trim_pkg::low_flags_type flags_reg, flags_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [2:0] cmp_meta_reg, cmp_sync_reg;
  logic pup_meta_reg, pup_sync_reg, pup_prev_reg;
  logic [2:0] below;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cmp_meta_reg <= 3'h0;
      cmp_sync_reg <= 3'h0;
      // Reset to the powered level so release gives no false power-up edge
      pup_meta_reg <= 1'b1;
      pup_sync_reg <= 1'b1;
      pup_prev_reg <= 1'b1;
    end else begin
      cmp_meta_reg <= below;
      cmp_sync_reg <= cmp_meta_reg;
      pup_meta_reg <= main_powerup;
      pup_sync_reg <= pup_meta_reg;
      pup_prev_reg <= pup_sync_reg;
    end
  end

  always_comb begin
    below[2] = main_supply_mv < main_trip_mv;
    below[1] = battery_mv < first_trip_mv;
    below[0] = battery_mv < second_trip_mv;
  end

  always_comb begin
    supply_sel_next = supply_sel_reg;
    first_sel_next = first_sel_reg;
    second_sel_next = second_sel_reg;
    disconnect_next = disconnect_reg;
    clear_next = 1'b0;
    trim_next = trim_reg;
    trim_loaded_next = 1'b1;
    flags_next = flags_reg;
    rdata_next = rdata_reg;
    // Preset copied once after reset, writes never touch it
    if (!trim_loaded_reg) begin
      trim_next = trim_preset;
    end
    if (bus.wr && bus.addr == supply_trim_pkg::supply_trip_control_addr) begin
      supply_sel_next = bus.wdata[2:0];
      clear_next = bus.wdata[supply_trim_pkg::clear_stamps_pos];
    end
    if (bus.wr && bus.addr == supply_trim_pkg::battery_trip_control_addr) begin
      disconnect_next = bus.wdata[supply_trim_pkg::disconnect_pos];
      // No cross check between the two selects
      first_sel_next = bus.wdata[supply_trim_pkg::first_sel_lsb +: 3];
      second_sel_next = bus.wdata[2:0];
    end
    if (pup_sync_reg && !pup_prev_reg) begin
      disconnect_next = 1'b0;
    end
    if ((status_read_stop && auto_clear_enable) || status_flag_clear) begin
      flags_next = '0;
    end
    // Set wins over clear in the same cycle
    if (cmp_sync_reg[2]) flags_next.main_low = 1'b1;
    if (cmp_sync_reg[1]) flags_next.first_low = 1'b1;
    if (cmp_sync_reg[0]) flags_next.second_low = 1'b1;
    if (bus.rd) begin
      case (bus.addr)
        supply_trim_pkg::supply_trip_control_addr: rdata_next = {5'h00, supply_sel_reg};
        supply_trim_pkg::battery_trip_control_addr:
          rdata_next = {1'b0, disconnect_reg, first_sel_reg, second_sel_reg};
        supply_trim_pkg::initial_trim_setting_addr: rdata_next = trim_reg;
        supply_trim_pkg::status_addr:
          rdata_next = {4'h0, flags_reg.main_low, flags_reg.first_low,
                        flags_reg.second_low, 1'b0};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      supply_sel_reg <= supply_trim_pkg::supply_sel_reset;
      first_sel_reg <= supply_trim_pkg::battery_sel_reset;
      second_sel_reg <= supply_trim_pkg::battery_sel_reset;
      disconnect_reg <= 1'b0;
      clear_reg <= 1'b0;
      trim_reg <= 8'h00;
      trim_loaded_reg <= 1'b0;
      flags_reg <= '0;
      rdata_reg <= 8'h00;
    end else begin
      supply_sel_reg <= supply_sel_next;
      first_sel_reg <= first_sel_next;
      second_sel_reg <= second_sel_next;
      disconnect_reg <= disconnect_next;
      clear_reg <= clear_next;
      trim_reg <= trim_next;
      trim_loaded_reg <= trim_loaded_next;
      flags_reg <= flags_next;
      rdata_reg <= rdata_next;
    end
  end

  always_comb begin
    rdata = rdata_reg;
    clear_stamps_pulse = clear_reg;
    battery_connected = !disconnect_reg;
    main_trip_mv = main_level(supply_sel_reg);
    first_trip_mv = first_level(first_sel_reg);
    second_trip_mv = second_level(second_sel_reg);
    flags = flags_reg;
    initial_digital_trim = supply_trim_pkg::digital_trim_type'(trim_reg[7:6]);
    initial_analog_trim = trim_reg[5:0];
    // Bit 1 skip pulses, bit 0 insert pulses
    case (initial_digital_trim)
      supply_trim_pkg::trim_plus: pulse_adjust = 2'b01;
      supply_trim_pkg::trim_minus: pulse_adjust = 2'b10;
      default: pulse_adjust = 2'b00;
    endcase
  end
endmodule // supply_monitor_trim_regs
`default_nettype wire

// ---- hdl/supply_trim_pkg.sv ----
// Constants and carriers for the supply monitor and trim register bank.
// Assumes a byte-wide register port decoded by the serial front end.
// Function
// - Writing one to clear stamps bit clears both switchover stamps; bit reads zero.
// - Main supply select picks brownout level 2.295 V up to 4.675 V.
// - Main supply below selected level sets the main supply low flag.
// - Battery trip register at 0Ah holds both battery threshold selects.
// - Battery disconnect bit set to one disconnects the backup battery pin.
// - After main supply power cycle the disconnect bit clears, battery reconnects.
// - First battery select encodes seven levels, 2.125 V to 4.675 V.
// - Second battery select encodes seven levels, 1.875 V to 4.125 V.
// - Either battery select accepts any level with no cross check.
// - Initial trim loads factory preset at power-up and ignores writes.
// - Digital trim decodes disabled, plus 30.5, zero, minus 30.5 ppm.
// - Digital trim skips or inserts pulses; combined range +62.5 to -61.5 ppm.
// - Battery low flags set when battery falls below selected levels.
// - With auto clear, low flags clear after status read ending in stop.
package supply_trim_pkg;
  localparam logic [7:0] supply_trip_control_addr = 8'h09;
  localparam logic [7:0] battery_trip_control_addr = 8'h0a;
  localparam logic [7:0] initial_trim_setting_addr = 8'h0b;
  localparam logic [7:0] status_addr = 8'h07;
  localparam int clear_stamps_pos = 7;
  localparam int disconnect_pos = 6;
  localparam int first_sel_lsb = 3;
  localparam int main_low_pos = 3;
  localparam int first_low_pos = 2;
  localparam int second_low_pos = 1;
  localparam logic [2:0] supply_sel_reset = 3'h0;
  localparam logic [2:0] battery_sel_reset = 3'h0;
  // Preset value arbitrary: 00 digital disabled, analog code 20h is 0 ppm
  localparam logic [7:0] trim_preset_default = 8'h20;
  // Threshold levels in millivolts, one entry per select code
  localparam int level_width = 13;
  localparam logic [12:0] level_reserved = 13'h0000;
  typedef enum logic [1:0] {
    trim_disabled = 2'b00,
    trim_plus = 2'b01,
    trim_zero = 2'b10,
    trim_minus = 2'b11
  } digital_trim_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_type;
  typedef struct packed {
    logic main_low;
    logic first_low;
    logic second_low;
  } low_flags_type;
endpackage

// ---- test/supply_monitor_trim_regs_checker.sv ----
// Port checker for the supply monitor and trim register bank.
// Assumes one clock and a synchronous active-low reset; bound in below.
`default_nettype none
module supply_monitor_trim_regs_checker #(
  parameter logic [7:0] trim_preset = supply_trim_pkg::trim_preset_default
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire supply_trim_pkg::reg_access_type bus,
  input wire logic status_read_stop,
  input wire logic auto_clear_enable,
  input wire logic main_powerup,
  input wire logic [12:0] main_supply_mv,
  input wire logic [7:0] rdata,
  input wire logic clear_stamps_pulse,
  input wire logic battery_connected,
  input wire logic [12:0] main_trip_mv,
  input wire logic [12:0] first_trip_mv,
  input wire supply_trim_pkg::low_flags_type flags
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int main_lv[8] = '{2295, 2550, 2805, 3060, 4250, 4675, 0, 0};
  localparam int first_lv[8] = '{2125, 2295, 2550, 2805, 3060, 4250, 4675, 0};
  wire logic wr_main = bus.wr && bus.addr == 8'h09;
  wire logic wr_bat = bus.wr && bus.addr == 8'h0a;
  wire logic wr_disc = wr_bat && bus.wdata[6];
  wire logic [2:0] sel_lo = bus.wdata[2:0];
  wire logic [2:0] sel_hi = bus.wdata[5:3];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  clear_pulse_a: assert property (wr_main && bus.wdata[7] |=> clear_stamps_pulse)
    else $error("clear stamps pulse missing");
  main_level_a: assert property (wr_main |=> main_trip_mv == main_lv[$past(sel_lo)])
    else $error("main trip level wrong");
  first_level_a: assert property (wr_bat |=> first_trip_mv == first_lv[$past(sel_hi)])
    else $error("first battery level wrong");
  disconnect_a: assert property (wr_disc && main_powerup && $past(main_powerup, 4)
    |=> !battery_connected) else $error("battery still connected");
  reconnect_a: assert property ($rose(main_powerup) |-> ##[1:5] battery_connected)
    else $error("battery not reconnected");
  main_low_a: assert property (main_supply_mv < main_trip_mv |-> ##[1:5] flags.main_low)
    else $error("main low flag not set");
  flag_clear_a: assert property ($fell(flags.main_low)
    |-> $past(status_read_stop && auto_clear_enable)) else $error("flag cleared unasked");
  trim_read_a: assert property (bus.rd && bus.addr == 8'h0b |=> rdata == trim_preset)
    else $error("trim copy not preset");
  clear_seen_c: cover property (clear_stamps_pulse);
  reconnect_seen_c: cover property ($rose(battery_connected));
  auto_clear_seen_c: cover property (status_read_stop && auto_clear_enable && flags.main_low);
endmodule // supply_monitor_trim_regs_checker
bind supply_monitor_trim_regs supply_monitor_trim_regs_checker
  #(.trim_preset(trim_preset)) i_chk (.mclk, .rst_b, .bus, .status_read_stop,
  .auto_clear_enable, .main_powerup, .main_supply_mv, .rdata, .clear_stamps_pulse,
  .battery_connected, .main_trip_mv, .first_trip_mv, .flags);
`default_nettype wire

// ---- test/supply_monitor_trim_regs_test.sv ----
// Self-checking bench for the supply monitor and trim register bank.
// Assumes the checker file binds itself to the design.
`default_nettype none
module supply_monitor_trim_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] preset = 8'h5f;
  int main_lv[8] = '{2295, 2550, 2805, 3060, 4250, 4675, 0, 0};
  int first_lv[8] = '{2125, 2295, 2550, 2805, 3060, 4250, 4675, 0};
  int second_lv[8] = '{1875, 2025, 2250, 2475, 2700, 3750, 4125, 0};
  int seed = 51, bad_count = 0, check_count = 0, i, r;
  logic mclk = 0, rst_b = 0, stop = 0, aclr = 0, pwr = 1, csp, conn;
  logic [12:0] vmain = 13'h1388, vbat = 13'h1388, mtv, ftv, stv;
  logic [7:0] rdata;
  logic [1:0] idt, padj;
  logic [5:0] iat;
  supply_trim_pkg::reg_access_type bus = '0;
  supply_trim_pkg::low_flags_type flags;
  supply_monitor_trim_regs #(.trim_preset(preset)) i_dut (.mclk, .rst_b, .bus,
    .status_read_stop(stop), .auto_clear_enable(aclr), .status_flag_clear(1'b0),
    .main_powerup(pwr), .main_supply_mv(vmain), .battery_mv(vbat), .rdata,
    .clear_stamps_pulse(csp), .battery_connected(conn), .main_trip_mv(mtv),
    .first_trip_mv(ftv), .second_trip_mv(stv), .flags, .initial_digital_trim(idt),
    .initial_analog_trim(iat), .pulse_adjust(padj));
  initial forever #5 mclk = ~mclk;
  task automatic chk(input logic [12:0] got, input int exp);
    check_count++;
    if (got !== exp[12:0]) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp[12:0]);
    end
  endtask
  // Strobe lowered a cycle later so two accesses never share a time step
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    bus = '{w, !w, a, d};
    @(negedge mclk);
    bus = '0;
  endtask
  task automatic rd(input logic [7:0] a, input int exp);
    acc(1'b0, a, 8'h00);
    chk(rdata, exp);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (12) @(negedge mclk);
    rst_b = 1;
    rd(8'h09, 0);
    acc(1'b1, 8'h0b, 8'h00);
    rd(8'h0b, preset);
    chk(idt, 1);
    chk(iat, 8'h1f);
    chk(padj, 1);
    rd(8'h0c, 0);
    $display("test reset_readonly done");
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      acc(1'b1, 8'h09, {r[7], 4'h0, i[2:0]});
      chk(csp, r[7]);
      chk(mtv, main_lv[i]);
      rd(8'h09, i);
      acc(1'b1, 8'h0a, {r[15:14], i[2:0], ~i[2:0]});
      chk(ftv, first_lv[i]);
      chk(stv, second_lv[7 - i]);
      chk(conn, !r[14]);
      rd(8'h0a, {r[14], i[2:0], ~i[2:0]});
    end
    $display("test trip_selects done");
    acc(1'b1, 8'h0a, 8'h40);
    chk(conn, 0);
    pwr = 0;
    repeat (5) @(negedge mclk);
    pwr = 1;
    for (i = 0; i < 20 && !conn; i++) @(negedge mclk);
    chk(conn, 1);
    if (conn !== 1'b1) stop_test;
    rd(8'h0a, 0);
    $display("test power_cycle done");
    acc(1'b1, 8'h09, 8'h00);
    acc(1'b1, 8'h0a, 8'h08);
    vmain = 13'h07d0;
    vbat = 13'h07d0;
    repeat (6) @(negedge mclk);
    rd(8'h07, 8'h0c);
    vmain = 13'h1388;
    vbat = 13'h0708;
    repeat (6) @(negedge mclk);
    rd(8'h07, 8'h0e);
    vbat = 13'h1388;
    repeat (6) @(negedge mclk);
    aclr = 1;
    stop = 1;
    @(negedge mclk);
    stop = 0;
    rd(8'h07, 0);
    $display("test low_flags done");
    stop_test;
  end
endmodule // supply_monitor_trim_regs_test
`default_nettype wire
